// File: rtl/obl_clk_div.sv
// system clock source select: pass-through for crystal, divide by two for rc
// assumes the oscillator pin is slower than a quarter of core_clk
`timescale 1ns/1ns
module obl_clk_div
  import obl_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic oscPin,
  input  wire logic rcMode,
  output      logic sysClkOut
);

  logic [2:0] syncPin_ff;
  logic       pinLvl_ff;
  logic       pinLvlDly_ff;
  logic       divTgl_ff;
  logic       sysClk_ff;
  logic       nxt_sysClk;

  // ==========================================================================
  // pin synchroniser and filter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncPin_ff <= 3'h0;
    end else begin
      syncPin_ff <= {syncPin_ff[1:0], oscPin};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinLvl_ff    <= 1'b0;
      pinLvlDly_ff <= 1'b0;
    end else begin
      if (syncPin_ff[1] == syncPin_ff[2]) begin
        pinLvl_ff <= syncPin_ff[2];
      end
      pinLvlDly_ff <= pinLvl_ff;
    end
  end

  // ==========================================================================
  // divider
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divTgl_ff <= 1'b0;
    end else if (pinLvl_ff && !pinLvlDly_ff) begin
      divTgl_ff <= !divTgl_ff;
    end
  end

  always_comb begin
    nxt_sysClk = rcMode ? divTgl_ff : pinLvl_ff;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysClk_ff <= 1'b0;
    end else begin
      sysClk_ff <= nxt_sysClk;
    end
  end

  assign sysClkOut = sysClk_ff;

endmodule

// File: rtl/obl_option_loader.sv
// option byte loader: fetches the option byte on every reset and drives config
// assumes a flash read port that answers each request with a one-cycle valid
`timescale 1ns/1ns
module obl_option_loader
  import obl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // reset sources
  input  wire logic        extResetPinN,
  input  wire logic        stopRecovery,
  // flash read port
  output      logic        flashRdReq,
  output      logic [15:0] flashRdAddr,
  input  wire logic        flashRdValid,
  input  wire logic [7:0]  flashRdData,
  // processor, watchdog, oscillator, brownout, debug and flash controls
  output      logic        cpuRunEn,
  input  wire logic        wdtInstr,
  input  wire logic        wdtTimeout,
  input  wire logic        globalIntEn,
  output      logic        wdtRunning,
  output      logic        wdtIrqReq,
  output      logic        wdtResetReq,
  output      logic [1:0]  oscDriveMode,
  input  wire logic        oscillator_input_pin,
  output      logic        sysClkOut,
  input  wire logic        stopMode,
  output      logic        brownoutEn,
  output      logic        codeReadable,
  output      logic        debugFullCmds,
  output      logic        userFlashWriteEn,
  output      logic        debugMassEraseEn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  obl_state_t  state_ff;
  obl_state_t  nxt_state;
  obl_cfg_t    cfg_ff;
  obl_status_t status;
  logic [2:0]  syncRst_ff;
  logic        extLow_ff;
  logic        swRstReq_ff;
  logic        reloadReq;
  logic        flashRdReq_ff;
  logic [15:0] flashRdAddr_ff;
  logic        cpuRun_ff;
  logic        loadDone_ff;
  logic        rsvByteFault_ff;
  logic        rsvBitFault_ff;
  logic [7:0]  loadCount_ff;
  logic        wdtRun_ff;
  logic        wdtIrq_ff;
  logic        wdtRst_ff;
  logic        brownout_ff;
  logic        awHeld_ff;
  logic        wHeld_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awReady_ff;
  logic        wReady_ff;
  logic        bValid_ff;
  logic [1:0]  bResp_ff;
  logic        arReady_ff;
  logic        rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;
  logic        awTake;
  logic        wTake;
  logic        wrGo;
  logic        arTake;

  // ==========================================================================
  // external reset pin synchroniser and filter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncRst_ff <= 3'h7;
    end else begin
      syncRst_ff <= {syncRst_ff[1:0], extResetPinN};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extLow_ff <= 1'b0;
    end else if (syncRst_ff[1] == syncRst_ff[2]) begin
      extLow_ff <= !syncRst_ff[2];
    end
  end

  // any reset cause restarts the load
  assign reloadReq = extLow_ff || stopRecovery || swRstReq_ff || wdtRst_ff;

  // ==========================================================================
  // loader sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LD_HOLD: begin
        if (!extLow_ff) begin
          nxt_state = LD_USER;
        end
      end
      LD_USER: begin
        if (flashRdValid) begin
          nxt_state = LD_RSVD;
        end
      end
      LD_RSVD: begin
        if (flashRdValid) begin
          nxt_state = LD_RUN;
        end
      end
      LD_RUN: begin
        nxt_state = LD_RUN;
      end
    endcase
    if (reloadReq) begin
      nxt_state = LD_HOLD;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= LD_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // flash request is held until the answer arrives
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flashRdReq_ff  <= 1'b0;
      flashRdAddr_ff <= OPT_USER_ADDR;
    end else begin
      flashRdReq_ff  <= (nxt_state == LD_USER) || (nxt_state == LD_RSVD);
      flashRdAddr_ff <= (nxt_state == LD_RSVD) ? OPT_RESERVED_ADDR : OPT_USER_ADDR;
    end
  end

  // configuration latched only while loading
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= CFG_ERASED;
    end else if (state_ff == LD_USER && flashRdValid && !reloadReq) begin
      cfg_ff.watchdog_timeout_action <= flashRdData[OPT_WDT_ACTION_BIT];
      cfg_ff.watchdog_always_on      <= flashRdData[OPT_WATCHDOG_ALWAYS_ON_BIT];
      cfg_ff.oscillator_mode_select  <= obl_osc_t'(flashRdData[OPT_OSC_HI_BIT:OPT_OSC_LO_BIT]);
      cfg_ff.brownout_keep_on        <= flashRdData[OPT_BO_KEEP_BIT];
      cfg_ff.read_protect            <= flashRdData[OPT_RD_PROT_BIT];
      cfg_ff.flash_write_protect     <= flashRdData[OPT_FWP_BIT];
    end
  end

  // load bookkeeping and reserved-content checks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loadDone_ff     <= 1'b0;
      rsvByteFault_ff <= 1'b0;
      rsvBitFault_ff  <= 1'b0;
      loadCount_ff    <= 8'h00;
    end else begin
      if (reloadReq) begin
        loadDone_ff <= 1'b0;
      end else if (state_ff == LD_RSVD && flashRdValid) begin
        loadDone_ff     <= 1'b1;
        loadCount_ff    <= loadCount_ff + 8'h01;
        rsvByteFault_ff <= (flashRdData != OPT_ERASED);
      end
      if (state_ff == LD_USER && flashRdValid && !reloadReq) begin
        rsvBitFault_ff <= !flashRdData[OPT_RSVD_BIT];
      end
    end
  end

  // processor held until the configuration is in place
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuRun_ff <= 1'b0;
    end else begin
      cpuRun_ff <= (nxt_state == LD_RUN);
    end
  end

  // ==========================================================================
  // watchdog policy
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdtRun_ff <= 1'b0;
    end else if (reloadReq || state_ff != LD_RUN) begin
      wdtRun_ff <= 1'b0;
    end else if (!cfg_ff.watchdog_always_on || wdtInstr) begin
      wdtRun_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdtIrq_ff <= 1'b0;
      wdtRst_ff <= 1'b0;
    end else begin
      wdtIrq_ff <= wdtTimeout && wdtRun_ff && !cfg_ff.watchdog_timeout_action
                   && globalIntEn;
      wdtRst_ff <= wdtTimeout && wdtRun_ff && cfg_ff.watchdog_timeout_action;
    end
  end

  // ==========================================================================
  // brownout
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      brownout_ff <= 1'b1;
    end else begin
      brownout_ff <= cfg_ff.brownout_keep_on || !stopMode;
    end
  end

  // ==========================================================================
  // system clock source
  obl_clk_div u_clk_div (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .oscPin    (oscillator_input_pin),
    .rcMode    (cfg_ff.oscillator_mode_select == OSC_RC),
    .sysClkOut (sysClkOut)
  );

  // ==========================================================================
  // AXI4-Lite write path
  assign awTake = s_axi_awvalid && awReady_ff;
  assign wTake  = s_axi_wvalid && wReady_ff;
  assign wrGo   = (awHeld_ff || awTake) && (wHeld_ff || wTake) && !bValid_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else begin
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      awHeld_ff <= wrGo ? 1'b0 : (awHeld_ff || awTake);
      wHeld_ff  <= wrGo ? 1'b0 : (wHeld_ff || wTake);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awReady_ff <= 1'b0;
      wReady_ff  <= 1'b0;
    end else begin
      awReady_ff <= !(awHeld_ff || awTake) && !bValid_ff && !wrGo;
      wReady_ff  <= !(wHeld_ff || wTake) && !bValid_ff && !wrGo;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_ff   <= 1'b0;
      bResp_ff    <= RESP_OKAY;
      swRstReq_ff <= 1'b0;
    end else begin
      swRstReq_ff <= 1'b0;
      if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
      if (wrGo) begin
        bValid_ff <= 1'b1;
        bResp_ff  <= RESP_OKAY;
        // status is read only; the option configuration has no address
        if (awTake ? (s_axi_awaddr == REG_CTRL_OFS) : (awAddr_ff == REG_CTRL_OFS)) begin
          swRstReq_ff <= (wTake ? s_axi_wstrb[0] && s_axi_wdata[CTRL_SWRST_BIT]
                                : wStrb_ff[0] && wData_ff[CTRL_SWRST_BIT]);
        end else if (awTake ? (s_axi_awaddr != REG_STATUS_OFS)
                            : (awAddr_ff != REG_STATUS_OFS)) begin
          bResp_ff <= RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  assign arTake = s_axi_arvalid && arReady_ff;

  always_comb begin
    status.loadCount         = loadCount_ff;
    status.reservedBitFault  = rsvBitFault_ff;
    status.reservedByteFault = rsvByteFault_ff;
    status.loadDone          = loadDone_ff;
    status.state             = state_ff;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arReady_ff <= 1'b0;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h0000_0000;
      rResp_ff   <= RESP_OKAY;
    end else begin
      arReady_ff <= !rValid_ff && !arTake;
      if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
      end
      if (arTake) begin
        rValid_ff <= 1'b1;
        rResp_ff  <= RESP_OKAY;
        rData_ff  <= 32'h0000_0000;
        if (s_axi_araddr == REG_STATUS_OFS) begin
          rData_ff[ST_CNT_LO+7:ST_CNT_LO]       <= status.loadCount;
          rData_ff[ST_RSVBIT_BIT]               <= status.reservedBitFault;
          rData_ff[ST_RSVB_BIT]                 <= status.reservedByteFault;
          rData_ff[ST_DONE_BIT]                 <= status.loadDone;
          rData_ff[ST_STATE_LO+1:ST_STATE_LO]   <= status.state;
        end else if (s_axi_araddr != REG_CTRL_OFS) begin
          rResp_ff <= RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops except debugMassEraseEn, tied to 1; config changes only through a reload
  assign flashRdReq       = flashRdReq_ff;
  assign flashRdAddr      = flashRdAddr_ff;
  assign cpuRunEn         = cpuRun_ff;
  assign wdtRunning       = wdtRun_ff;
  assign wdtIrqReq        = wdtIrq_ff;
  assign wdtResetReq      = wdtRst_ff;
  assign oscDriveMode     = cfg_ff.oscillator_mode_select;
  assign brownoutEn       = brownout_ff;
  assign codeReadable     = cfg_ff.read_protect;
  assign debugFullCmds    = cfg_ff.read_protect;
  assign userFlashWriteEn = cfg_ff.flash_write_protect;
  assign debugMassEraseEn = 1'b1;
  assign s_axi_awready    = awReady_ff;
  assign s_axi_wready     = wReady_ff;
  assign s_axi_bvalid     = bValid_ff;
  assign s_axi_bresp      = bResp_ff;
  assign s_axi_arready    = arReady_ff;
  assign s_axi_rvalid     = rValid_ff;
  assign s_axi_rdata      = rData_ff;
  assign s_axi_rresp      = rResp_ff;

endmodule

// File: rtl/obl_pkg.sv
// package for the option byte loader: offsets, field positions, defaults, types
// assumes a 32-bit AXI4-Lite register bus and an 8-bit flash read port
package obl_pkg;

  // ==========================================================================
  // flash locations
  localparam logic [15:0] OPT_USER_ADDR     = 16'h0000;
  localparam logic [15:0] OPT_RESERVED_ADDR = 16'h0001;
  localparam logic [7:0]  OPT_ERASED        = 8'hFF;

  // ==========================================================================
  // option byte field positions
  localparam int OPT_WDT_ACTION_BIT = 7;
  localparam int OPT_WATCHDOG_ALWAYS_ON_BIT     = 6;
  localparam int OPT_OSC_HI_BIT     = 5;
  localparam int OPT_OSC_LO_BIT     = 4;
  localparam int OPT_BO_KEEP_BIT    = 3;
  localparam int OPT_RD_PROT_BIT    = 2;
  localparam int OPT_RSVD_BIT       = 1;
  localparam int OPT_FWP_BIT        = 0;

  // ==========================================================================
  // oscillator modes
  typedef enum logic [1:0] {
    OSC_RC  = 2'b00,
    OSC_MIN = 2'b01,
    OSC_MED = 2'b10,
    OSC_MAX = 2'b11
  } obl_osc_t;

  // ==========================================================================
  // loader states
  typedef enum logic [1:0] {
    LD_HOLD = 2'b00,
    LD_USER = 2'b01,
    LD_RSVD = 2'b10,
    LD_RUN  = 2'b11
  } obl_state_t;

  // ==========================================================================
  // active configuration
  typedef struct packed {
    logic     watchdog_timeout_action;
    logic     watchdog_always_on;
    obl_osc_t oscillator_mode_select;
    logic     brownout_keep_on;
    logic     read_protect;
    logic     flash_write_protect;
  } obl_cfg_t;

  localparam obl_cfg_t CFG_ERASED = '{
    watchdog_timeout_action: 1'b1,
    watchdog_always_on:      1'b1,
    oscillator_mode_select:  OSC_MAX,
    brownout_keep_on:        1'b1,
    read_protect:            1'b1,
    flash_write_protect:     1'b1
  };

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam int         CTRL_SWRST_BIT = 0;
  localparam int         ST_STATE_LO    = 0;
  localparam int         ST_DONE_BIT    = 2;
  localparam int         ST_RSVB_BIT    = 3;
  localparam int         ST_RSVBIT_BIT  = 4;
  localparam int         ST_CNT_LO      = 8;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  typedef struct packed {
    logic [7:0] loadCount;
    logic       reservedBitFault;
    logic       reservedByteFault;
    logic       loadDone;
    obl_state_t state;
  } obl_status_t;

endpackage

// File: verif/obl_flash_model.sv
// flash array model: answers each read request with a one-cycle valid
// assumes the loader holds request and address until valid is sampled
`timescale 1ns/1ns
module obl_flash_model
  import obl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  userByte,
  input  wire logic [7:0]  rsvdByte,
  input  wire logic [3:0]  latency,
  input  wire logic        flashRdReq,
  input  wire logic [15:0] flashRdAddr,
  output      logic        flashRdValid,
  output      logic [7:0]  flashRdData
);
  // ==========================================================================
  // read port
  logic [3:0] waitCnt_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flashRdValid <= 1'b0;
      flashRdData  <= 8'h00;
      waitCnt_ff   <= 4'h0;
    end else if (flashRdValid) begin
      flashRdValid <= 1'b0;
      flashRdData  <= ~flashRdData;
    end else if (flashRdReq && waitCnt_ff >= latency) begin
      flashRdValid <= 1'b1;
      waitCnt_ff   <= 4'h0;
      flashRdData  <= (flashRdAddr == OPT_USER_ADDR) ? userByte : rsvdByte;
    end else begin
      waitCnt_ff   <= flashRdReq ? waitCnt_ff + 4'h1 : 4'h0;
      flashRdData  <= ~flashRdData;
    end
  end
endmodule

// File: verif/obl_option_loader_assertions.sv
// checker for the option loader: load order, release and config timing
// assumes binding to obl_option_loader with ports of the same names
`timescale 1ns/1ns
module obl_option_loader_assertions
  import obl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        stopRecovery,
  input wire logic        flashRdReq,
  input wire logic [15:0] flashRdAddr,
  input wire logic        flashRdValid,
  input wire logic [7:0]  flashRdData,
  input wire logic        cpuRunEn,
  input wire logic        wdtTimeout,
  input wire logic        globalIntEn,
  input wire logic        wdtRunning,
  input wire logic        wdtIrqReq,
  input wire logic [1:0]  oscDriveMode,
  input wire logic        stopMode,
  input wire logic        brownoutEn,
  input wire logic        codeReadable,
  input wire logic        debugFullCmds,
  input wire logic        userFlashWriteEn
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic userTake;
  logic rsvdTake;
  assign userTake = flashRdReq && flashRdValid && flashRdAddr == OPT_USER_ADDR;
  assign rsvdTake = flashRdReq && flashRdValid && flashRdAddr == OPT_RESERVED_ADDR;

  // ==========================================================================
  // assertions
  req_hold_a: assert property (flashRdReq && !flashRdValid && !stopRecovery
    |=> flashRdReq && $stable(flashRdAddr)) else $error("flash request dropped early");
  addr_order_a: assert property (userTake && !stopRecovery
    |=> flashRdReq && flashRdAddr == OPT_RESERVED_ADDR) else $error("second byte not fetched");
  run_after_a: assert property ($rose(cpuRunEn) |-> $past(rsvdTake))
    else $error("processor released before load");
  stop_drop_a: assert property (stopRecovery |=> !cpuRunEn)
    else $error("stop recovery did not hold processor");
  cfg_load_a: assert property (userTake && !stopRecovery
    |=> oscDriveMode == $past(flashRdData[5:4]) && codeReadable == $past(flashRdData[2])
        && userFlashWriteEn == $past(flashRdData[0])) else $error("config not loaded");
  cfg_hold_a: assert property (!userTake
    |=> $stable(oscDriveMode) && $stable(codeReadable) && $stable(userFlashWriteEn))
    else $error("config changed without load");
  brown_on_a: assert property (!stopMode |=> brownoutEn)
    else $error("brownout off outside stop");
  irq_cause_a: assert property (wdtIrqReq |-> $past(wdtTimeout && globalIntEn && wdtRunning))
    else $error("spurious watchdog interrupt");
  dbg_match_a: assert property (userTake && !stopRecovery
    |=> debugFullCmds == $past(flashRdData[2])) else $error("debug commands not loaded");

  // ==========================================================================
  // covers
  cover property (rsvdTake);
  cover property ($rose(cpuRunEn));
  cover property (wdtIrqReq);
endmodule

bind obl_option_loader obl_option_loader_assertions i_obl_option_loader_assertions (
  .core_clk, .sys_rst, .stopRecovery, .flashRdReq, .flashRdAddr, .flashRdValid,
  .flashRdData, .cpuRunEn, .wdtTimeout, .globalIntEn, .wdtRunning, .wdtIrqReq,
  .oscDriveMode, .stopMode, .brownoutEn, .codeReadable, .debugFullCmds, .userFlashWriteEn);

// File: verif/testbench.sv
// testbench for the option loader: reloads, config outputs, register bus
// assumes the flash model as partner and AXI4-Lite tasks as master
`timescale 1ns/1ns
module testbench
  import obl_pkg::*;
;
  logic core_clk = 0, sys_rst = 1, extResetPinN = 1, stopRecovery = 0, wdtInstr = 0;
  logic wdtTimeout = 0, globalIntEn = 0, oscillator_input_pin = 0, stopMode = 0;
  logic flashRdReq, flashRdValid, cpuRunEn, wdtRunning, wdtIrqReq, wdtResetReq, sysClkOut;
  logic brownoutEn, codeReadable, debugFullCmds, userFlashWriteEn, debugMassEraseEn;
  logic [15:0] flashRdAddr;
  logic [7:0]  flashRdData, userByte = 8'hFF, rsvdByte = 8'hFF, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0]  latency = 4'h3, s_axi_wstrb = 0;
  logic [1:0]  oscDriveMode, s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0, n_checks = 0, cyc = 0, irqCnt = 0, rstCnt = 0, n;

  obl_option_loader i_obl_option_loader (.*);
  obl_flash_model i_obl_flash_model (.*);

  // ==========================================================================
  // clocks, timeout, pulse monitor
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc % 8 == 0) oscillator_input_pin <= ~oscillator_input_pin;
    if (wdtIrqReq === 1'b1) irqCnt++;
    if (wdtResetReq === 1'b1) rstCnt++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  // ==========================================================================
  // tasks
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task chk_rng(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: %s count %0d", $time, what, got);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rsp = s_axi_rresp;
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task wait_run(input logic v);
    do @(posedge core_clk); while (cpuRunEn !== v);
  endtask
  task stop_reload;
    stopRecovery <= 1'b1;
    @(posedge core_clk);
    stopRecovery <= 1'b0;
    wait_run(1'b0);
    wait_run(1'b1);
  endtask
  task check_cfg(input logic [7:0] b);
    chk(oscDriveMode, b[5:4], "osc");
    chk(codeReadable, b[2], "read");
    chk(debugFullCmds, b[2], "debug");
    chk(userFlashWriteEn, b[0], "write");
    chk(debugMassEraseEn, 1'h1, "erase");
  endtask
  task count_clk(input int lo, input int hi);
    logic p;
    n = 0;
    p = sysClkOut;
    repeat (640) begin
      @(posedge core_clk);
      if (sysClkOut && !p) n++;
      p = sysClkOut;
    end
    chk_rng(n, lo, hi, "sysclk");
  endtask
  task pulse_wdt(input logic instr);
    if (instr) wdtInstr <= 1'b1;
    else wdtTimeout <= 1'b1;
    @(posedge core_clk);
    wdtInstr <= 1'b0;
    wdtTimeout <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // ==========================================================================
  // sequence
  initial begin
    repeat (6) @(posedge core_clk);
    check_cfg(8'hFF);
    sys_rst <= 1'b0;
    wait_run(1'b1);
    check_cfg(8'hFF);
    chk(wdtRunning, 1'h0, "wdt");
    axi_rd(REG_STATUS_OFS);
    chk({rsp, d[15:0]}, {RESP_OKAY, 16'h0107}, "status");
    axi_rd(REG_CTRL_OFS);
    chk({rsp, d}, {RESP_OKAY, 32'h0}, "ctrl");
    axi_rd(8'h08);
    chk({rsp, d}, {RESP_SLVERR, 32'h0}, "unmapped rd");
    axi_wr(8'h0C, 32'hFF);
    chk(rsp, RESP_SLVERR, "unmapped wr");
    axi_wr(REG_STATUS_OFS, 32'h1);
    chk({rsp, cpuRunEn}, {RESP_OKAY, 1'h1}, "status wr");
    userByte <= 8'h47;
    repeat (20) @(posedge core_clk);
    check_cfg(8'hFF);
    count_clk(39, 41);
    stop_reload;
    check_cfg(8'h47);
    count_clk(19, 21);
    stopMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(brownoutEn, 1'h0, "bo stop");
    stopMode <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(brownoutEn, 1'h1, "bo run");
    pulse_wdt(1'b1);
    chk(wdtRunning, 1'h1, "wdt instr");
    globalIntEn <= 1'b1;
    pulse_wdt(1'b0);
    chk(irqCnt, 32'h1, "irq");
    globalIntEn <= 1'b0;
    pulse_wdt(1'b0);
    chk({irqCnt, rstCnt}, {32'h1, 32'h0}, "irq off");
    latency <= 4'h0;
    userByte <= 8'h13;
    axi_wr(REG_CTRL_OFS, 32'h1);
    wait_run(1'b0);
    wait_run(1'b1);
    check_cfg(8'h13);
    repeat (2) @(posedge core_clk);
    chk(wdtRunning, 1'h1, "wdt on");
    userByte <= 8'hFF;
    extResetPinN <= 1'b0;
    wait_run(1'b0);
    repeat (10) @(posedge core_clk);
    chk(cpuRunEn, 1'h0, "ext hold");
    extResetPinN <= 1'b1;
    wait_run(1'b1);
    check_cfg(8'hFF);
    chk(wdtRunning, 1'h0, "wdt off");
    stopMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(brownoutEn, 1'h1, "bo keep");
    stopMode <= 1'b0;
    pulse_wdt(1'b1);
    wdtTimeout <= 1'b1;
    @(posedge core_clk);
    wdtTimeout <= 1'b0;
    wait_run(1'b0);
    wait_run(1'b1);
    chk({irqCnt, rstCnt}, {32'h1, 32'h1}, "wdt reset");
    userByte <= 8'hED;
    rsvdByte <= 8'h7F;
    stop_reload;
    axi_rd(REG_STATUS_OFS);
    chk({rsp, d[15:0]}, {RESP_OKAY, 16'h061F}, "faults");
    check_cfg(8'hED);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check_cfg(8'hFF);
    sys_rst <= 1'b0;
    wait_run(1'b1);
    check_cfg(8'hED);
    end_sim;
  end
endmodule
